// file: include/bcr_pkg.sv
// constants and types shared by the bridge channel register bank
package bcr_pkg;
    // register map, byte offsets in the 16 kbyte operational block
    localparam logic [13:0] BCR_CFG_OFF = 14'h0000;
    localparam logic [3:0] BCR_FILT_LO = 4'h2;
    localparam logic [3:0] BCR_BAL_LO = 4'h4;
    localparam logic [13:0] BCR_SCAN_BASE = 14'h0100;
    localparam logic [13:0] BCR_SCAN_TOP = 14'h02fe;
    localparam int BCR_NCHAN = 8;
    localparam int BCR_SCAN_DEPTH = 256;
    localparam int BCR_DAC_W = 12;
    // configuration register fields
    localparam int BCR_CFG_FEN_BIT = 4;
    localparam int BCR_CFG_RUN_BIT = 5;
    localparam logic [15:0] BCR_CFG_ONES = 16'hf080;
    localparam logic [5:0] BCR_CFG_RST = 6'h00;
    // bridge balance register fields
    localparam int BCR_BAL_POLN_BIT = 12;
    localparam int BCR_BAL_POLP_BIT = 13;
    localparam int BCR_BAL_SHA_BIT = 14;
    localparam int BCR_BAL_SHB_BIT = 15;
    localparam logic [15:0] BCR_BAL_RST = 16'h0000;
    localparam logic [3:0] BCR_BAND_RST = 4'h0;
    // scan entry fields
    localparam int BCR_ENT_LAST_BIT = 15;
    localparam int BCR_ENT_SEL_BIT = 14;
    // scan sequencer states
    typedef enum logic [1:0] {
        BCR_SC_SETUP = 2'b01,
        BCR_SC_RUN = 2'b10
    } bcr_scan_type;
endpackage

// file: core/bcr_scan_ram.sv
// scan table memory with a host port and a sequencer read port
`timescale 1ns/10ps
module bcr_scan_ram
    import bcr_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int WIDTH = 16,
    parameter int AW = 8
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] host_addr,
    output logic [WIDTH-1:0] host_q,
    input wire logic [AW-1:0] scan_addr,
    output logic [WIDTH-1:0] scan_q
);
    typedef struct packed {
        logic [WIDTH-1:0] host_q;
        logic [WIDTH-1:0] scan_q;
    } bcr_ram_type;

    logic [WIDTH-1:0] mem [DEPTH];
    bcr_ram_type s_r;
    bcr_ram_type s_nxt;

    // contents are not cleared by reset
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // both read ports are registered
    always_comb begin
        s_nxt = s_r;
        s_nxt.host_q = mem[host_addr];
        s_nxt.scan_q = mem[scan_addr];
    end

    always_ff @(posedge mclk) begin
        s_r <= s_nxt;
    end

    assign host_q = s_r.host_q;
    assign scan_q = s_r.scan_q;
endmodule

// file: core/bcr_regs.sv
// channel registers and scan sequencer of the bridge conditioner
// How it works
// - filters act only when enable bit set
// - shunt bits 14/15 connect shunt resistor
// - bit 12 negative, bit 13 positive polarity
// - bits 11-0 drive balance dac
// - eight balance registers at offsets N4h
// - scan memory holds 256 sixteen-bit words
// - one scan entry per adc clock
// - bit 15 marks last table entry
// - bit 14 puts channel on bus
// - bits 7-0 carry channel number
// - code zero means physical channel one
// - up to 256 slots per sample period
// - low two code bits pick path
// - scan loads only in setup mode
`timescale 1ns/10ps
module bcr_regs
    import bcr_pkg::*;
#(
    parameter int NCHAN = BCR_NCHAN,
    parameter int DEPTH = BCR_SCAN_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [13:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic adc_tick,
    output logic run_mode,
    output logic [NCHAN*4-1:0] filt_band,
    output logic filt_bypass,
    output logic [NCHAN-1:0] shunt_a,
    output logic [NCHAN-1:0] shunt_b,
    output logic [NCHAN-1:0] bal_neg,
    output logic [NCHAN-1:0] bal_pos,
    output logic [NCHAN*BCR_DAC_W-1:0] bal_dac,
    output logic mux_drive,
    output logic [1:0] mux_path,
    output logic [NCHAN-1:0] mux_chan_sel,
    output logic scan_last,
    output logic [7:0] scan_ptr
);
    typedef struct packed {
        logic [5:0] cfg;
        logic [NCHAN-1:0][3:0] band;
        logic [NCHAN-1:0][15:0] bal;
        logic [NCHAN-1:0][3:0] fsel;
        logic bypass;
        bcr_scan_type st;
        logic [7:0] ptr;
        logic drive;
        logic [1:0] path;
        logic [NCHAN-1:0] chsel;
        logic last;
        logic rd1;
        logic rram;
        logic [15:0] rhold;
        logic [15:0] rdata;
        logic rvalid;
    } bcr_state_type;

    bcr_state_type s_r;
    bcr_state_type s_nxt;
    logic [15:0] host_q;
    logic [15:0] scan_q;
    logic scan_hit;
    logic ram_we;
    logic [7:0] ram_idx;

    // channel register decode: returns {hit, index} for low nibble lo
    function automatic logic [3:0] chan_dec(input logic [13:0] a, input logic [3:0] lo);
        logic [3:0] r;
        r = 4'h0;
        if (a[13:8] == 6'h00 && a[3:0] == lo && a[7:4] >= 4'h1 && a[7:4] <= 4'h8) begin
            r = {1'b1, 3'(a[7:4] - 4'h1)};
        end
        return r;
    endfunction

    // scan memory window, one 16-bit word per even byte address
    assign scan_hit = reg_addr >= BCR_SCAN_BASE && reg_addr <= BCR_SCAN_TOP && !reg_addr[0];
    assign ram_idx = 8'((reg_addr - BCR_SCAN_BASE) >> 1);
    assign ram_we = reg_wr && scan_hit && !s_r.cfg[BCR_CFG_RUN_BIT];

    bcr_scan_ram #(
        .DEPTH(DEPTH),
        .WIDTH(16),
        .AW(8)
    ) u_ram (
        .mclk(mclk),
        .wr_en(ram_we),
        .wr_addr(ram_idx),
        .wr_data(reg_wdata),
        .host_addr(ram_idx),
        .host_q(host_q),
        .scan_addr(s_r.ptr),
        .scan_q(scan_q)
    );

    // next state: register writes, readback pipeline, scan sequencer
    always_comb begin
        logic [3:0] fd;
        logic [3:0] bd;
        fd = chan_dec(reg_addr, BCR_FILT_LO);
        bd = chan_dec(reg_addr, BCR_BAL_LO);
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        s_nxt.rd1 = reg_rd;
        s_nxt.rram = reg_rd && scan_hit;
        if (reg_wr && reg_addr == BCR_CFG_OFF) begin
            s_nxt.cfg = reg_wdata[5:0];
        end
        if (reg_wr && fd[3]) begin
            s_nxt.band[fd[2:0]] = reg_wdata[3:0];
        end
        if (reg_wr && bd[3]) begin
            s_nxt.bal[bd[2:0]] = reg_wdata;
        end
        // register readback, held one stage in step with the memory port
        s_nxt.rhold = 16'h0000;
        if (reg_addr == BCR_CFG_OFF) begin
            s_nxt.rhold = BCR_CFG_ONES | {10'h000, s_r.cfg};
        end else if (fd[3]) begin
            s_nxt.rhold = {12'h000, s_r.band[fd[2:0]]};
        end else if (bd[3]) begin
            s_nxt.rhold = s_r.bal[bd[2:0]];
        end
        if (s_r.rd1) begin
            s_nxt.rdata = s_r.rram ? host_q : s_r.rhold;
            s_nxt.rvalid = 1'b1;
        end
        // filter band routing gated by the enable bit
        for (int i = 0; i < NCHAN; i++) begin
            s_nxt.fsel[i] = s_r.cfg[BCR_CFG_FEN_BIT] ? s_r.band[i] : 4'h0;
        end
        s_nxt.bypass = !s_r.cfg[BCR_CFG_FEN_BIT];
        // scan sequencer
        case (s_r.st)
            BCR_SC_SETUP: begin
                s_nxt.ptr = 8'h00;
                s_nxt.drive = 1'b0;
                s_nxt.chsel = '0;
                s_nxt.last = 1'b0;
                if (s_r.cfg[BCR_CFG_RUN_BIT]) begin
                    s_nxt.st = BCR_SC_RUN;
                end
            end
            BCR_SC_RUN: begin
                if (!s_r.cfg[BCR_CFG_RUN_BIT]) begin
                    s_nxt.st = BCR_SC_SETUP;
                    s_nxt.drive = 1'b0;
                    s_nxt.chsel = '0;
                end else if (adc_tick) begin
                    s_nxt.drive = scan_q[BCR_ENT_SEL_BIT];
                    s_nxt.path = scan_q[1:0];
                    s_nxt.last = scan_q[BCR_ENT_LAST_BIT];
                    s_nxt.chsel = '0;
                    if (scan_q[BCR_ENT_SEL_BIT] && scan_q[7:0] < 8'(NCHAN)) begin
                        s_nxt.chsel[scan_q[2:0]] = 1'b1;
                    end
                    if (scan_q[BCR_ENT_LAST_BIT]) begin
                        s_nxt.ptr = 8'h00;
                    end else begin
                        s_nxt.ptr = s_r.ptr + 8'h01;
                    end
                end
            end
            default: begin
                s_nxt.st = BCR_SC_SETUP;
            end
        endcase
    end

    // state register with synchronous reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.cfg <= BCR_CFG_RST;
            s_r.band <= {NCHAN{BCR_BAND_RST}};
            s_r.bal <= {NCHAN{BCR_BAL_RST}};
            s_r.bypass <= 1'b1;
            s_r.st <= BCR_SC_SETUP;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = s_r.rdata;
    assign reg_rvalid = s_r.rvalid;
    assign run_mode = s_r.st[1]; // one-hot run bit of the sequencer
    assign filt_band = s_r.fsel;
    assign filt_bypass = s_r.bypass;
    assign mux_drive = s_r.drive;
    assign mux_path = s_r.path;
    assign mux_chan_sel = s_r.chsel;
    assign scan_last = s_r.last;
    assign scan_ptr = s_r.ptr;
    generate
        for (genvar g = 0; g < NCHAN; g++) begin : g_bal
            assign shunt_a[g] = s_r.bal[g][BCR_BAL_SHA_BIT];
            assign shunt_b[g] = s_r.bal[g][BCR_BAL_SHB_BIT];
            assign bal_neg[g] = s_r.bal[g][BCR_BAL_POLN_BIT];
            assign bal_pos[g] = s_r.bal[g][BCR_BAL_POLP_BIT];
            assign bal_dac[g*BCR_DAC_W +: BCR_DAC_W] = s_r.bal[g][BCR_DAC_W-1:0];
        end
    endgenerate

    // checks on the sequencer and register outputs
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire tick_run = adc_tick && run_mode && s_r.cfg[BCR_CFG_RUN_BIT];

    a_scan_wrap: assert property (
        tick_run && scan_q[15] |=> scan_ptr == 8'h00 && scan_last)
        else $error("pointer did not restart after last entry");
    a_scan_step: assert property (
        tick_run && !scan_q[15] |=> scan_ptr == $past(scan_ptr) + 8'h01)
        else $error("pointer did not advance on adc tick");
    a_drive_select: assert property (
        tick_run |=> mux_drive == $past(scan_q[14]))
        else $error("bus drive does not follow module select");
    a_path_code: assert property (
        tick_run |=> mux_path == $past(scan_q[1:0]))
        else $error("path does not follow low code bits");
    a_chan_map: assert property (
        tick_run && scan_q[14] && scan_q[7:3] == 5'h00
        |=> mux_chan_sel == (8'h01 << $past(scan_q[2:0])))
        else $error("channel code maps to wrong channel");
    a_filt_gate: assert property (
        !s_r.cfg[4] ##1 !s_r.cfg[4] |-> filt_bypass && filt_band == '0)
        else $error("filters applied while disabled");
    a_ram_lock: assert property (
        s_r.cfg[5] && reg_wr && scan_hit
        |=> u_ram.mem[$past(ram_idx)] == $past(u_ram.mem[ram_idx]))
        else $error("scan memory written in run mode");
    a_bal_write: assert property (
        reg_wr && reg_addr == 14'h0014
        |=> bal_dac[11:0] == $past(reg_wdata[11:0]) && shunt_a[0] == $past(reg_wdata[14]))
        else $error("channel one balance not updated");
    // pointer clears one cycle after the drive, once setup is reached
    a_setup_quiet: assert property (
        !s_r.cfg[5] ##1 !s_r.cfg[5] |-> !mux_drive ##1 scan_ptr == 8'h00)
        else $error("bus driven in setup mode");
    a_read_lat: assert property (
        reg_rd |-> ##2 reg_rvalid)
        else $error("read answer not two cycles later");

    // filter routing, channel decode and mode handover
    a_filt_apply: assert property (
        s_r.cfg[4] ##1 s_r.cfg[4] |-> !filt_bypass && filt_band == $past(s_r.band))
        else $error("filters not applied while enabled");
    a_chan_none: assert property (
        tick_run && !(scan_q[14] && scan_q[7:3] == 5'h00) |=> mux_chan_sel == '0)
        else $error("local channel selected for foreign entry");
    a_bal_last: assert property (
        reg_wr && reg_addr == 14'h0084
        |=> bal_pos[7] == $past(reg_wdata[13]) && bal_neg[7] == $past(reg_wdata[12])
            && shunt_b[7] == $past(reg_wdata[15]))
        else $error("channel eight balance not updated");
    a_mode_enter: assert property (
        !run_mode && s_r.cfg[5] |=> run_mode)
        else $error("run mode not entered");
    a_mode_leave: assert property (
        run_mode && !s_r.cfg[5] |=> !run_mode && !mux_drive && mux_chan_sel == '0)
        else $error("bus still driven after leaving run mode");

    // readback of fixed fields
    a_cfg_read: assert property (
        reg_rd && reg_addr == BCR_CFG_OFF
        |-> ##2 reg_rdata[15:12] == 4'hf && reg_rdata[7] && reg_rdata[11:8] == 4'h0)
        else $error("configuration readback ones wrong");
    a_unmapped: assert property (
        reg_rd && reg_addr == 14'h3ffe |-> ##2 reg_rdata == 16'h0000)
        else $error("unmapped read not zero");

    c_wrap: cover property (tick_run && scan_q[15]);
    c_drive: cover property (tick_run && scan_q[14] ##1 mux_drive);
    c_ram_read: cover property (reg_rd && scan_hit ##2 reg_rvalid);
    c_filter_on: cover property (s_r.cfg[4] && filt_band != '0);
    c_run_write: cover property (s_r.cfg[5] && reg_wr && scan_hit);
endmodule

// file: bench/bcr_adc_model.sv
// adc clock enable source standing on the far side of the scan link
`timescale 1ns/10ps
module bcr_adc_model #(
    parameter int GAP = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic run,
    output logic adc_tick
);
    int cnt;
    // one tick every GAP cycles, silent while the bank is in setup
    always_ff @(posedge mclk) begin
        if (!rst_n || !run) begin
            cnt <= 0;
            adc_tick <= 1'b0;
        end else begin
            cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
            adc_tick <= (cnt == GAP - 1);
        end
    end
endmodule

// file: bench/tb_bridge_channel_regs_scan_table.sv
// self-checking bench for the bridge channel register bank
`timescale 1ns/10ps
module tb_bridge_channel_regs_scan_table;
    import bcr_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] reg_addr = 14'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, d;
    logic reg_rvalid, adc_tick, run_mode, filt_bypass, mux_drive, scan_last;
    logic [31:0] filt_band;
    logic [7:0] shunt_a, shunt_b, bal_neg, bal_pos, mux_chan_sel, scan_ptr;
    logic [95:0] bal_dac;
    logic [1:0] mux_path;
    logic [15:0] ent [4] = '{16'h4000, 16'h0005, 16'h4006, 16'hc00b};
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    // clock at 20 MHz
    always #25 mclk = ~mclk;
    bcr_regs uut (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid, .adc_tick, .run_mode, .filt_band, .filt_bypass, .shunt_a, .shunt_b,
        .bal_neg, .bal_pos, .bal_dac, .mux_drive, .mux_path, .mux_chan_sel, .scan_last,
        .scan_ptr);
    bcr_adc_model #(.GAP(4)) adc (.mclk, .rst_n, .run(run_mode), .adc_tick);
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one write strobe, released at the following edge
    task automatic wr(input logic [13:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // one read strobe, then wait for the answer pulse
    task automatic rd(input logic [13:0] a, input logic [15:0] exp, input string name);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            #1;
            if (reg_rvalid === 1'b1)
                break;
        end
        chk("reg_rvalid", 16'(reg_rvalid), 16'h0001);
        chk(name, reg_rdata, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        settle();
        chk("filt_bypass", 16'(filt_bypass), 16'h0001);
        rd(BCR_CFG_OFF, 16'hf080, "cfg");
        rd(14'h3ffe, 16'h0000, "unmapped");
        $display("reset test done");
        // one band bit per channel on channels one to four, every band bit once
        for (int b = 0; b < 4; b++)
            wr({6'h00, 4'(b + 1), 4'h2}, 16'h0001 << b);
        wr(BCR_CFG_OFF, 16'h0010);
        settle();
        chk("filt_band", filt_band[15:0], 16'h8421);
        chk("filt_bypass", 16'(filt_bypass), 16'h0000);
        rd({6'h00, 4'h2, 4'h2}, 16'h0002, "filt_reg");
        wr(BCR_CFG_OFF, 16'h0000);
        settle();
        chk("filt_band", filt_band[15:0], 16'h0000);
        $display("filter test done");
        // every balance register, each control bit in turn
        for (int k = 0; k < 8; k++) begin
            d = (16'h1000 << (k % 4)) | (16'(k) * 16'h0111);
            wr({6'h00, 4'(k + 1), 4'h4}, d);
            settle();
            chk("bal_dac", 16'(bal_dac[12*k+:12]), {4'h0, d[11:0]});
            chk("pol", 16'({bal_pos[k], bal_neg[k]}), 16'(d[13:12]));
            chk("shunt", 16'({shunt_b[k], shunt_a[k]}), 16'(d[15:14]));
            rd({6'h00, 4'(k + 1), 4'h4}, d, "bal");
        end
        $display("balance test done");
        // scan table: paths A to D, last entry flagged
        for (int i = 0; i < 4; i++)
            wr(BCR_SCAN_BASE + 14'(2 * i), ent[i]);
        wr(BCR_SCAN_TOP, 16'h8123);
        rd(BCR_SCAN_TOP, 16'h8123, "scan_top");
        wr(BCR_CFG_OFF, 16'h0020);
        wr(BCR_SCAN_BASE, 16'h0001);
        rd(BCR_SCAN_BASE, 16'h4000, "scan_run_wr");
        chk("run_mode", 16'(run_mode), 16'h0001);
        for (int i = 0; i < 8; i++) begin
            // look at the tick off the edge so its launch edge is not raced
            for (int j = 0; j < 10 && adc_tick !== 1'b1; j++) begin
                @(posedge mclk);
                #1;
            end
            @(posedge mclk);
            #1;
            d = ent[i % 4];
            chk("mux_drive", 16'(mux_drive), 16'(d[14]));
            chk("mux_path", 16'(mux_path), 16'(d[1:0]));
            chk("chan_sel", 16'(mux_chan_sel),
                (d[14] && d[7:0] < 8) ? 16'h0001 << d[2:0] : 16'h0000);
            chk("scan_last", 16'(scan_last), 16'(d[15]));
            chk("scan_ptr", 16'(scan_ptr), d[15] ? 16'h0000 : 16'(i % 4 + 1));
        end
        wr(BCR_CFG_OFF, 16'h0000);
        settle();
        chk("run_mode", 16'(run_mode), 16'h0000);
        chk("mux_drive", 16'(mux_drive), 16'h0000);
        chk("scan_ptr", 16'(scan_ptr), 16'h0000);
        $display("scan test done");
        stop_test();
    end
endmodule
